// file: bench/auto_wake_sleep_control_props.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checks
// ----------------------------------------
module auto_wake_sleep_control_props
	import aws_pkg::*;
(
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       transient_event,
	input wire logic       orientation_event,
	input wire logic       tap_event,
	input wire logic       freefall_motion_event,
	input wire logic       fifo_flush,
	input wire logic       fifo_accept,
	input wire logic       sleep_mode,
	input wire logic [1:0] sleep_rate_out,
	input wire logic [2:0] wake_rate_out,
	input wire logic       use_sleep_rate,
	input wire logic       sleep_transition_event
);
	logic wake_ev;
	assign wake_ev = transient_event | orientation_event | tap_event | freefall_motion_event;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_rate_override: assert property (use_sleep_rate == sleep_mode)
		else $error("rate override differs from sleep mode");
	a_pulse_on_change: assert property (sleep_transition_event |-> sleep_mode != $past(sleep_mode))
		else $error("transition pulse without mode change");
	a_wake_has_cause: assert property ($fell(sleep_mode) |->
		$past(wake_ev | reg_write) || $past(reg_write, 2))
		else $error("left sleep without a wake event");
	a_sleep_rate_src: assert property ($changed(sleep_rate_out) |->
		$past(reg_write) && $past(reg_addr) == ADDR_SYSTEM_CONTROL_ONE)
		else $error("sleep rate changed without a write");
	a_wake_rate_src: assert property ($changed(wake_rate_out) |->
		$past(reg_write) && $past(reg_addr) == ADDR_SYSTEM_CONTROL_ONE)
		else $error("wake rate changed without a write");
	a_accept_resume: assert property ($rose(fifo_accept) |->
		$past(fifo_flush) || $past(reg_write) || $past(reg_write, 2))
		else $error("fifo accept resumed without flush");
	a_accept_hold: assert property ($fell(fifo_accept) |-> sleep_transition_event ||
		$past(sleep_transition_event) || $past(reg_write) || $past(reg_write, 2))
		else $error("fifo accept dropped without transition");
	a_unmapped_zero: assert property (!($past(reg_addr) inside {8'h29, 8'h2a, 8'h2b,
		8'h2c, 8'h2d, 8'h0b}) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind auto_wake_sleep_control auto_wake_sleep_control_props i_props (.clk, .srst, .reg_write,
	.reg_addr, .reg_rdata, .transient_event, .orientation_event, .tap_event,
	.freefall_motion_event, .fifo_flush, .fifo_accept, .sleep_mode, .sleep_rate_out,
	.wake_rate_out, .use_sleep_rate, .sleep_transition_event);

// file: bench/auto_wake_sleep_control_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench with 8/16 cycle timer steps
// ----------------------------------------
module auto_wake_sleep_control_tb;
	import aws_pkg::*;
	logic       clk = 1'b0, srst = 1'b1, reg_write = 1'b0, fifo_flush = 1'b0;
	logic       transient_event = 1'b0, orientation_event = 1'b0;
	logic       tap_event = 1'b0, freefall_motion_event = 1'b0;
	logic       sample_ready_event = 1'b0, fifo_gate_event = 1'b0;
	logic       fifo_accept, sleep_mode, use_sleep_rate, sleep_transition_event;
	logic [1:0] sleep_rate_out;
	logic [2:0] wake_rate_out;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	int         error_cnt = 0, n_tests = 0, pulses = 0, n = 0;
	auto_wake_sleep_control #(.SHORT_CYCLES(8), .LONG_CYCLES(16)) i_auto_wake_sleep_control (
		.clk, .srst, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .transient_event,
		.orientation_event, .tap_event, .freefall_motion_event, .sample_ready_event,
		.fifo_gate_event, .fifo_flush, .fifo_accept, .sleep_mode, .sleep_rate_out,
		.wake_rate_out, .use_sleep_rate, .sleep_transition_event);
	initial forever #20 clk = ~clk;
	always @(negedge clk) if (sleep_transition_event === 1'b1) pulses++;
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		chk("rdata", reg_rdata, exp);
	endtask
	task automatic hit(logic [3:0] e);
		{transient_event, orientation_event, tap_event, freefall_motion_event} <= e;
		@(posedge clk);
		{transient_event, orientation_event, tap_event, freefall_motion_event} <= 4'h0;
		@(posedge clk);
	endtask
	task automatic wait_mode(logic exp, int lim);
		for (n = 0; sleep_mode !== exp && n < lim; n++)
			@(posedge clk);
		if (sleep_mode !== exp) begin
			chk("mode wait", 8'(sleep_mode), 8'(exp));
			results();
		end
	endtask
	task automatic t_reset();
		rd(ADDR_INACTIVITY_DURATION, RESET_BYTE);
		rd(ADDR_SYSTEM_CONTROL_ONE, RESET_BYTE);
		rd(ADDR_SYSTEM_CONTROL_TWO, RESET_BYTE);
		rd(ADDR_WAKE_SELECT_CONTROL, RESET_BYTE);
		rd(ADDR_POWER_STATUS, RESET_BYTE);
		chk("accept", 8'(fifo_accept), 8'h00);
	endtask
	task automatic t_regs();
		wr(ADDR_INACTIVITY_DURATION, 8'ha5);
		rd(ADDR_INACTIVITY_DURATION, 8'ha5);
		wr(8'h30, 8'h5a);
		rd(8'h30, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_SYSTEM_CONTROL_ONE, {2'(r), 3'(r), 3'h0});
			chk("sleep rate", 8'(sleep_rate_out), 8'(r));
			chk("wake rate", 8'(wake_rate_out), 8'(r));
		end
	endtask
	task automatic t_awake();
		wr(ADDR_INACTIVITY_DURATION, 8'h02);
		wr(ADDR_INTERRUPT_ENABLE, 8'hf8);
		wr(ADDR_WAKE_SELECT_CONTROL, 8'h78);
		wr(ADDR_SYSTEM_CONTROL_ONE, 8'h01);
		repeat (100) @(posedge clk);
		chk("mode", 8'(sleep_mode), 8'h00);
		rd(ADDR_POWER_STATUS, 8'h01);
		chk("accept", 8'(fifo_accept), 8'h01);
	endtask
	task automatic t_sleep();
		pulses = 0;
		wr(ADDR_SYSTEM_CONTROL_TWO, 8'h04);
		hit(4'h2);
		wait_mode(1'b1, 40);
		chk("short delay", 8'(n), 8'h18);
		chk("override", 8'(use_sleep_rate), 8'h01);
		chk("pulses", 8'(pulses), 8'h01);
		rd(ADDR_POWER_STATUS, 8'h02);
	endtask
	task automatic t_restart();
		hit(4'h8);
		repeat (6) begin
			repeat (10) @(posedge clk);
			hit(4'h2);
			chk("mode", 8'(sleep_mode), 8'h00);
		end
		sample_ready_event <= 1'b1;
		wait_mode(1'b1, 40);
		sample_ready_event <= 1'b0;
	endtask
	task automatic t_wake();
		wr(ADDR_INACTIVITY_DURATION, 8'h00);
		wr(ADDR_WAKE_SELECT_CONTROL, 8'h08);
		hit(4'h8);
		chk("mode", 8'(sleep_mode), 8'h01);
		wr(ADDR_INTERRUPT_ENABLE, 8'h80);
		hit(4'h1);
		chk("mode", 8'(sleep_mode), 8'h01);
		wr(ADDR_INTERRUPT_ENABLE, 8'hf8);
		wr(ADDR_WAKE_SELECT_CONTROL, 8'h78);
		for (int i = 0; i < 4; i++) begin
			{sample_ready_event, fifo_gate_event, fifo_flush} <= 3'h7;
			@(posedge clk);
			{sample_ready_event, fifo_gate_event, fifo_flush} <= 3'h0;
			@(posedge clk);
			chk("mode", 8'(sleep_mode), 8'h01);
			hit(4'(1 << i));
			chk("mode", 8'(sleep_mode), 8'h00);
			wait_mode(1'b1, 10);
		end
		chk("pulses", 8'(pulses), 8'h0b);
	endtask
	task automatic t_long();
		wr(ADDR_INACTIVITY_DURATION, 8'h01);
		wr(ADDR_SYSTEM_CONTROL_ONE, 8'h39);
		hit(4'h8);
		wait_mode(1'b1, 60);
		chk("long delay", 8'(n), 8'h20);
	endtask
	task automatic t_fifo();
		wr(ADDR_WAKE_SELECT_CONTROL, 8'hf8);
		hit(4'h8);
		chk("mode", 8'(sleep_mode), 8'h00);
		chk("accept", 8'(fifo_accept), 8'h00);
		fifo_flush <= 1'b1;
		@(posedge clk);
		fifo_flush <= 1'b0;
		@(posedge clk);
		chk("accept", 8'(fifo_accept), 8'h01);
		repeat (2) begin
			repeat (20) @(posedge clk);
			fifo_gate_event <= 1'b1;
			@(posedge clk);
			fifo_gate_event <= 1'b0;
			@(posedge clk);
			chk("gate restart", 8'(sleep_mode), 8'h00);
		end
		wait_mode(1'b1, 40);
		chk("gate delay", 8'(n), 8'h20);
		chk("accept", 8'(fifo_accept), 8'h00);
		wr(ADDR_SYSTEM_CONTROL_TWO, 8'h00);
		wait_mode(1'b0, 4);
		chk("pulses", 8'(pulses), 8'h10);
		chk("accept", 8'(fifo_accept), 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_regs();
		t_awake();
		t_sleep();
		t_restart();
		t_wake();
		t_long();
		t_fifo();
		results();
	end
endmodule

// file: pkg/aws_pkg.sv
package aws_pkg;
	// ----------------------------------------
	// Register offsets and fields
	// ----------------------------------------
	localparam logic [7:0] ADDR_INACTIVITY_DURATION = 8'h29;
	localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE  = 8'h2a;
	localparam logic [7:0] ADDR_SYSTEM_CONTROL_TWO  = 8'h2b;
	localparam logic [7:0] ADDR_WAKE_SELECT_CONTROL = 8'h2c;
	localparam logic [7:0] ADDR_INTERRUPT_ENABLE    = 8'h2d;
	localparam logic [7:0] ADDR_POWER_STATUS        = 8'h0b;
	localparam logic [7:0] RESET_BYTE               = 8'h00;
	localparam int         FIFO_GATE_BIT            = 7;
	localparam int         AUTO_SLEEP_ENABLE_BIT    = 2;
	localparam int         WAKE_RATE_LSB            = 3;
	localparam int         SLEEP_RATE_LSB           = 6;
	// Event bit positions in interrupt enable; wake select shares bits 3 to 6
	localparam int         EV_FREEFALL_MOTION       = 3;
	localparam int         EV_TAP                   = 4;
	localparam int         EV_ORIENTATION           = 5;
	localparam int         EV_TRANSIENT             = 6;
	localparam int         EV_SLEEP_TRANSITION      = 7;
	localparam int         EV_SAMPLE_READY          = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_HZ                   = 25_000_000;
	localparam int         STEP_SHORT_MS            = 320;
	localparam int         STEP_LONG_MS             = 640;
	localparam int         STEP_SHORT_CYCLES        = CLK_HZ / 1000 * STEP_SHORT_MS;
	localparam int         STEP_LONG_CYCLES         = CLK_HZ / 1000 * STEP_LONG_MS;
	localparam logic [2:0] WAKE_RATE_SLOWEST        = 3'h7;

	typedef enum logic [1:0] {
		RATE_50HZ,
		RATE_12P5HZ,
		RATE_6P25HZ,
		RATE_1P56HZ
	} sleep_rate_t;

	typedef enum logic [1:0] {
		MODE_STANDBY,
		MODE_WAKE,
		MODE_SLEEP
	} power_mode_t;
endpackage

// file: rtl/auto_wake_sleep_control.sv
`timescale 1ns/1ns
module auto_wake_sleep_control
	import aws_pkg::*;
#(
	parameter int SHORT_CYCLES = STEP_SHORT_CYCLES,
	parameter int LONG_CYCLES  = STEP_LONG_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       reg_write,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       transient_event,
	input  wire logic       orientation_event,
	input  wire logic       tap_event,
	input  wire logic       freefall_motion_event,
	input  wire logic       sample_ready_event,
	input  wire logic       fifo_gate_event,
	input  wire logic       fifo_flush,
	output logic            fifo_accept,
	output logic            sleep_mode,
	output logic [1:0]      sleep_rate_out,
	output logic [2:0]      wake_rate_out,
	output logic            use_sleep_rate,
	output logic            sleep_transition_event
);
	initial begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
			$error("auto_wake_sleep_control: bad step counts");
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  inactivity_duration_q;
	logic [7:0]  system_control_one_q;
	logic [7:0]  system_control_two_q;
	logic [7:0]  wake_select_control_q;
	logic [7:0]  interrupt_enable_control_q;
	power_mode_t mode_q;
	logic [7:0]  steps_q;
	logic        fifo_hold_q;
	logic        sleep_transition_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return reg_write && (a == b);
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			inactivity_duration_q      <= RESET_BYTE;
			system_control_one_q       <= RESET_BYTE;
			system_control_two_q       <= RESET_BYTE;
			wake_select_control_q      <= RESET_BYTE;
			interrupt_enable_control_q <= RESET_BYTE;
		end else begin
			if (hit(reg_addr, ADDR_INACTIVITY_DURATION))
				inactivity_duration_q <= reg_wdata;
			if (hit(reg_addr, ADDR_SYSTEM_CONTROL_ONE))
				system_control_one_q <= reg_wdata;
			if (hit(reg_addr, ADDR_SYSTEM_CONTROL_TWO))
				system_control_two_q <= reg_wdata;
			if (hit(reg_addr, ADDR_WAKE_SELECT_CONTROL))
				wake_select_control_q <= reg_wdata;
			if (hit(reg_addr, ADDR_INTERRUPT_ENABLE))
				interrupt_enable_control_q <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	logic       active;
	logic       auto_sleep_enable;
	logic       fifo_gate;
	logic [2:0] wake_data_rate_select;
	logic [1:0] sleep_rate_select;
	logic       keep_awake;
	logic       wake_request;
	logic       long_step;
	logic       tick;
	logic       going_sleep;
	logic       going_wake;
	logic [7:0] ev_vec;

	assign active                = system_control_one_q[0];
	assign auto_sleep_enable     = system_control_two_q[AUTO_SLEEP_ENABLE_BIT];
	assign fifo_gate             = wake_select_control_q[FIFO_GATE_BIT];
	assign wake_data_rate_select = system_control_one_q[WAKE_RATE_LSB +: 3];
	assign sleep_rate_select     = system_control_one_q[SLEEP_RATE_LSB +: 2];

	always_comb begin
		ev_vec                      = '0;
		ev_vec[EV_FREEFALL_MOTION]  = freefall_motion_event;
		ev_vec[EV_TAP]              = tap_event;
		ev_vec[EV_ORIENTATION]      = orientation_event;
		ev_vec[EV_TRANSIENT]        = transient_event;
	end

	// Enabled detector events and the FIFO gate restart the count
	assign keep_awake   = |(ev_vec & interrupt_enable_control_q)
		|| (fifo_gate && fifo_gate_event);
	// Sleep and data-ready events never enter either term
	assign wake_request = |(ev_vec & interrupt_enable_control_q
		& wake_select_control_q);

	// Step length follows the rate currently in force
	assign long_step = (mode_q == MODE_SLEEP) ? (sleep_rate_select == RATE_1P56HZ)
		: (wake_data_rate_select == WAKE_RATE_SLOWEST);

	step_timer #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES (LONG_CYCLES)
	) u_step (
		.clk      (clk),
		.srst     (srst),
		.run      (mode_q == MODE_WAKE && auto_sleep_enable),
		.restart  (keep_awake),
		.long_step(long_step),
		.tick     (tick)
	);

	// ----------------------------------------
	// Inactivity count and mode
	// ----------------------------------------
	assign going_sleep = mode_q == MODE_WAKE && auto_sleep_enable && !keep_awake
		&& tick && steps_q >= inactivity_duration_q;
	// Clearing auto-sleep while asleep is a wake transition too
	assign going_wake  = mode_q == MODE_SLEEP && active
		&& (wake_request || !auto_sleep_enable);

	always_ff @(posedge clk) begin
		if (srst || mode_q != MODE_WAKE || keep_awake)
			steps_q <= '0;
		else if (tick && steps_q != 8'hff)
			steps_q <= steps_q + 8'h01;
	end

	// Leaving active drops straight to standby from any mode
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q <= MODE_STANDBY;
		end else if (!active) begin
			mode_q <= MODE_STANDBY;
		end else begin
			unique case (mode_q)
				MODE_STANDBY: mode_q <= MODE_WAKE;
				MODE_WAKE:    if (going_sleep) mode_q <= MODE_SLEEP;
				MODE_SLEEP: begin
					if (going_wake)
						mode_q <= MODE_WAKE;
				end
				default:      mode_q <= MODE_STANDBY;
			endcase
		end
	end

	// ----------------------------------------
	// Transition event and FIFO gate
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst)
			sleep_transition_q <= 1'b0;
		else
			sleep_transition_q <= (going_sleep || going_wake)
				&& interrupt_enable_control_q[EV_SLEEP_TRANSITION];
	end

	always_ff @(posedge clk) begin
		if (srst)
			fifo_hold_q <= 1'b0;
		else if (fifo_gate && (going_sleep || going_wake)
				&& interrupt_enable_control_q[EV_SLEEP_TRANSITION])
			fifo_hold_q <= 1'b1;
		else if (fifo_flush)
			fifo_hold_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst)
			reg_rdata <= RESET_BYTE;
		else
			unique case (reg_addr)
				ADDR_INACTIVITY_DURATION: reg_rdata <= inactivity_duration_q;
				ADDR_SYSTEM_CONTROL_ONE:  reg_rdata <= system_control_one_q;
				ADDR_SYSTEM_CONTROL_TWO:  reg_rdata <= system_control_two_q;
				ADDR_WAKE_SELECT_CONTROL: reg_rdata <= wake_select_control_q;
				ADDR_INTERRUPT_ENABLE:    reg_rdata <= interrupt_enable_control_q;
				ADDR_POWER_STATUS:        reg_rdata <= {6'h00, mode_q};
				default:                  reg_rdata <= RESET_BYTE;
			endcase
	end

	assign fifo_accept            = !fifo_hold_q && mode_q != MODE_STANDBY;
	assign sleep_mode             = mode_q == MODE_SLEEP;
	assign use_sleep_rate         = mode_q == MODE_SLEEP;
	assign sleep_rate_out         = sleep_rate_select;
	assign wake_rate_out          = wake_data_rate_select;
	assign sleep_transition_event = sleep_transition_q;
	// Sample-ready is seen but deliberately affects nothing here
	logic unused_ok;
	assign unused_ok = sample_ready_event;
endmodule

// file: rtl/step_timer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Inactivity step tick generator
// ----------------------------------------
module step_timer #(
	parameter int SHORT_CYCLES = 8000000,
	parameter int LONG_CYCLES  = 16000000
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic run,
	input  wire logic restart,
	input  wire logic long_step,
	output logic      tick
);
	localparam int W = $clog2(LONG_CYCLES + 1);

	initial begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
			$error("step_timer: bad cycle counts");
	end

	logic [W-1:0] count_q;
	logic [W-1:0] limit;

	assign limit = long_step ? W'(LONG_CYCLES - 1) : W'(SHORT_CYCLES - 1);
	assign tick  = run && !restart && (count_q >= limit);

	always_ff @(posedge clk) begin
		if (srst || !run || restart || tick)
			count_q <= '0;
		else
			count_q <= count_q + W'(1);
	end
endmodule
